// >>> shared/vrc_pkg.sv
// Purpose: constants shared by the video memory random-port controller
// Assumes: 40 MHz core clock, 32-bit classic Wishbone register access
// Notes:   times are kept in their own unit, cycle counts derive from them
package vrc_pkg;
  localparam int CLK_MHZ = 40;

  // cycle count helpers: least times round up, longest times round down
  function automatic int ns_min_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_min_cyc

  function automatic int ns_max_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_max_cyc

  // register byte offsets
  localparam logic [7:0] ADR_CMD    = 8'h00;
  localparam logic [7:0] ADR_ADDR   = 8'h04;
  localparam logic [7:0] ADR_WDATA  = 8'h08;
  localparam logic [7:0] ADR_MASK   = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_RDATA  = 8'h14;

  // field positions
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_MASK_BIT = 3;
  localparam int CMD_KEEP_BIT = 4;
  localparam int CMD_BYTE_LSB = 5;
  localparam int ADDR_COL_LSB = 0;
  localparam int ADDR_ROW_LSB = 16;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_PAGE_BIT  = 1;
  localparam int ST_PERS_BIT  = 2;
  localparam int ST_DROP_BIT  = 3;
  localparam int ST_REF_BIT   = 4;

  // reset values
  localparam logic [15:0] MASK_RST = 16'hffff;
  localparam logic [6:0]  CMD_RST  = 7'h60;

  // command codes
  localparam logic [2:0] OP_READ    = 3'h0;
  localparam logic [2:0] OP_EARLY   = 3'h1;
  localparam logic [2:0] OP_LATE    = 3'h2;
  localparam logic [2:0] OP_RMW     = 3'h3;
  localparam logic [2:0] OP_LOADMSK = 3'h4;
  localparam logic [2:0] OP_REFRESH = 3'h5;

  // pin timing
  localparam int T_RP_NS   = 60;
  localparam int T_RCD_NS  = 20;
  localparam int T_CPA_NS  = 45;
  localparam int T_RAS_NS  = 80;
  localparam int T_GHD_NS  = 15;
  localparam int T_CWL_NS  = 20;
  localparam int T_RASP_NS = 100000;
  localparam int T_REF_MS  = 8;
  localparam int REF_ROWS  = 512;
  localparam int RP_CYC    = ns_min_cyc(T_RP_NS);
  localparam int RCD_CYC   = ns_min_cyc(T_RCD_NS);
  localparam int CAC_CYC   = ns_min_cyc(T_CPA_NS);
  localparam int RAS_CYC   = ns_min_cyc(T_RAS_NS);
  localparam int GHD_CYC   = ns_min_cyc(T_GHD_NS);
  localparam int CWL_CYC   = ns_min_cyc(T_CWL_NS);
  localparam int RASP_CYC  = ns_max_cyc(T_RASP_NS);
  localparam int REF_ROW_CYC = (T_REF_MS * CLK_MHZ * 1000) / REF_ROWS;

  typedef enum logic [3:0] {
    S_IDLE, S_ROW, S_COL, S_GAP, S_WR, S_END, S_CLOSE, S_PRE, S_CBR_C, S_CBR_R
  } vrc_state_type;
endpackage : vrc_pkg

// >>> shared/vrc_ref_if.sv
// Purpose: refresh request path between timer and sequencer
// Assumes: both ends on i_core_clk
// Notes:   req is a level held until ack pulses
`timescale 1ns/1ps
interface vrc_ref_if;
  logic req;
  logic ack;
  modport timer (output req, input ack);
  modport ctrl  (input req, output ack);
endinterface : vrc_ref_if

// >>> core/vrc_refresh_timer.sv
// Purpose: paces one row refresh per row interval
// Assumes: sequencer answers a request well inside one interval
// Notes:   a new tick in the same cycle as the ack is not lost
`timescale 1ns/1ps
module vrc_refresh_timer
  import vrc_pkg::*;
(
  input wire logic   i_core_clk, // core clock
  input wire logic   i_rst,      // async reset, active high
  vrc_ref_if.timer   ref_port    // request to sequencer
);
  logic [15:0] tick;
  logic [15:0] next_tick;
  logic        pend;
  logic        next_pend;
  logic [7:0]  age;
  logic [7:0]  next_age;
  logic        tick_hit;

  // interval counter and sticky request, the tick beats the ack
  always_comb
  begin
    tick_hit  = (tick == 16'(REF_ROW_CYC - 1));
    next_tick = tick_hit ? 16'h0000 : tick + 16'h0001;
    next_pend = tick_hit | (pend & ~ref_port.ack);
    next_age  = (pend && age != 8'hff) ? age + 8'h01 : (pend ? age : 8'h00);
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick <= 16'h0000;
      pend <= 1'b0;
      age  <= 8'h00;
    end
    else
    begin
      tick <= next_tick;
      pend <= next_pend;
      age  <= next_age;
    end
  end

  assign ref_port.req = pend;

  // pending refresh must be served quickly, far inside the row interval
  a_ref_served: assert property (@(posedge i_core_clk) disable iff (i_rst)
    age < 8'h40) else $error("refresh request waited too long");
endmodule : vrc_refresh_timer

// >>> core/vrc_ctrl.sv
// Purpose: host sequencer for a video memory random port, Wishbone register front
// Assumes: 40 MHz clock, device pins sampled synchronously, one command at a time
// Notes:   pages stay open only when the command asks; refresh closes them first
`timescale 1ns/1ps
module vrc_ctrl
  import vrc_pkg::*;
(
  input  wire logic        i_core_clk,                        // core clock
  input  wire logic        i_rst,                             // async reset, high
  input  wire logic        i_wb_cyc,                          // bus cycle
  input  wire logic        i_wb_stb,                          // bus strobe
  input  wire logic        i_wb_we,                           // bus write
  input  wire logic [7:0]  i_wb_adr,                          // byte address
  input  wire logic [31:0] i_wb_dat,                          // write data
  input  wire logic [3:0]  i_wb_sel,                          // byte lanes
  output logic      [31:0] o_wb_dat,                          // read data
  output logic             o_wb_ack,                          // bus answer
  output logic             o_row_strobe_n,                    // row strobe
  output logic             o_lower_byte_column_strobe_n,      // low column strobe
  output logic             o_upper_byte_column_strobe_n,      // high column strobe
  output logic             o_write_strobe_n,                  // write strobe
  output logic             o_output_enable_transfer_select_n, // output enable
  output logic             o_special_function_select,         // special function
  output logic      [8:0]  o_addr,                            // row/column address
  input  wire logic [15:0] i_random_data_io,                  // data pins in
  output logic      [15:0] o_random_data_io,                  // data pins out
  output logic             o_random_data_io_oe                // data pins drive
);
  vrc_ref_if ref_link ();

  vrc_refresh_timer u_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .ref_port   (ref_link.timer)
  );

  function automatic logic is_write(input logic [2:0] op);
    return (op == OP_EARLY) || (op == OP_LATE) || (op == OP_RMW);
  endfunction : is_write

  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction : wb_merge

  // bus side state
  logic        wb_ack, next_wb_ack;
  logic [31:0] wb_dat, next_wb_dat;
  logic [6:0]  cmd_reg, next_cmd_reg;
  logic [31:0] addr_reg, next_addr_reg;
  logic [15:0] wdata_reg, next_wdata_reg;
  logic [15:0] mask_reg, next_mask_reg;
  logic        cmd_pend, next_cmd_pend;
  logic        dropped, next_dropped;
  // sequencer state
  vrc_state_type st, next_st;
  logic [3:0]  cnt, next_cnt;
  logic [11:0] ras_age, next_ras_age;
  logic        page_open, next_page_open;
  logic        late_pg, next_late_pg;
  logic [8:0]  open_row, next_open_row;
  logic [1:0]  open_key, next_open_key;
  logic        persistent, next_persistent;
  logic        ras_n, next_ras_n;
  logic [1:0]  cas_n, next_cas_n;
  logic        we_n, next_we_n;
  logic        trg_n, next_trg_n;
  logic        special_function_select, next_dsf;
  logic [8:0]  addr, next_addr;
  logic [15:0] dq, next_dq;
  logic        dq_oe, next_dq_oe;
  logic [15:0] rdata, next_rdata;
  logic        ref_ack, next_ref_ack;
  logic [6:0]  cur_cmd, next_cur_cmd;
  logic [31:0] cur_addr, next_cur_addr;
  logic [15:0] cur_wdata, next_cur_wdata;
  logic        take, busy, wr_fire, page_hit;
  logic [2:0]  cmd_op, cur_op;
  logic [1:0]  cmd_key;

  assign cmd_op  = cmd_reg[CMD_OP_LSB +: 3];
  assign cur_op  = cur_cmd[CMD_OP_LSB +: 3];
  assign cmd_key = {cmd_reg[CMD_MASK_BIT] & is_write(cmd_op), cmd_op == OP_LOADMSK};
  assign busy    = cmd_pend | (st != S_IDLE);
  assign wr_fire = i_wb_cyc & i_wb_stb & i_wb_we & wb_ack;
  // reuse the open row when the row mode at row strobe matches
  assign page_hit = page_open && (addr_reg[ADDR_ROW_LSB +: 9] == open_row) &&
                    ((cmd_op == OP_READ) ? !late_pg :
                     ((cmd_key == open_key) && !(late_pg && cmd_op == OP_RMW)));

  // register slave: ack one cycle after request, writes land on the ack edge
  always_comb
  begin
    next_wb_ack    = i_wb_cyc & i_wb_stb & ~wb_ack;
    next_wb_dat    = wb_dat;
    next_cmd_reg   = cmd_reg;
    next_addr_reg  = addr_reg;
    next_wdata_reg = wdata_reg;
    next_mask_reg  = mask_reg;
    next_cmd_pend  = cmd_pend & ~take;
    next_dropped   = dropped;
    if (next_wb_ack && !i_wb_we)
    begin
      case (i_wb_adr)
        ADR_CMD:    next_wb_dat = {25'h0, cmd_reg};
        ADR_ADDR:   next_wb_dat = addr_reg;
        ADR_WDATA:  next_wb_dat = {16'h0, wdata_reg};
        ADR_MASK:   next_wb_dat = {16'h0, mask_reg};
        ADR_STATUS: next_wb_dat = {27'h0, ref_link.req, dropped, persistent, page_open, busy};
        ADR_RDATA:  next_wb_dat = {16'h0, rdata};
        default:    next_wb_dat = 32'h0000_0000;
      endcase
    end
    if (wr_fire)
    begin
      case (i_wb_adr)
        ADR_CMD:
        begin
          if (cmd_pend)
            next_dropped = 1'b1;
          else
          begin
            next_cmd_reg  = 7'(wb_merge({25'h0, cmd_reg}, i_wb_dat, i_wb_sel));
            next_cmd_pend = 1'b1;
          end
        end
        ADR_ADDR:   next_addr_reg  = wb_merge(addr_reg, i_wb_dat, i_wb_sel);
        ADR_WDATA:  next_wdata_reg = 16'(wb_merge({16'h0, wdata_reg}, i_wb_dat, i_wb_sel));
        // a one bit lets that data bit be written
        ADR_MASK:   next_mask_reg  = 16'(wb_merge({16'h0, mask_reg}, i_wb_dat, i_wb_sel));
        // write one to clear; a refusal in the same cycle wins over the clear
        ADR_STATUS: next_dropped   = (dropped & ~(i_wb_sel[0] & i_wb_dat[ST_DROP_BIT])) |
                                     (next_dropped & ~dropped);
        default:    next_dropped   = dropped;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wb_ack    <= 1'b0;
      wb_dat    <= 32'h0000_0000;
      cmd_reg   <= CMD_RST;
      addr_reg  <= 32'h0000_0000;
      wdata_reg <= 16'h0000;
      mask_reg  <= MASK_RST;
      cmd_pend  <= 1'b0;
      dropped   <= 1'b0;
    end
    else
    begin
      wb_ack    <= next_wb_ack;
      wb_dat    <= next_wb_dat;
      cmd_reg   <= next_cmd_reg;
      addr_reg  <= next_addr_reg;
      wdata_reg <= next_wdata_reg;
      mask_reg  <= next_mask_reg;
      cmd_pend  <= next_cmd_pend;
      dropped   <= next_dropped;
    end
  end

  // pin sequencer: every pin change lands on a clock edge
  always_comb
  begin
    next_st = st;  next_cnt = (cnt != 4'h0) ? cnt - 4'h1 : cnt;
    next_ras_age = ras_n ? 12'h000 : ((ras_age == 12'hfff) ? ras_age : ras_age + 12'h001);
    next_page_open = page_open;  next_late_pg = late_pg;
    next_open_row = open_row;  next_open_key = open_key;  next_persistent = persistent;
    next_ras_n = ras_n;  next_cas_n = cas_n;  next_we_n = we_n;  next_trg_n = trg_n;
    next_dsf = special_function_select;  next_addr = addr;  next_dq = dq;  next_dq_oe = dq_oe;
    next_rdata = rdata;  next_ref_ack = 1'b0;  take = 1'b0;
    next_cur_cmd = cur_cmd;  next_cur_addr = cur_addr;  next_cur_wdata = cur_wdata;
    case (st)
      S_IDLE:
      begin
        // refresh first so a busy command stream cannot starve it
        if (ref_link.req || (cmd_pend && cmd_op == OP_REFRESH))
        begin
          if (page_open)
            next_st = S_CLOSE;
          else
          begin
            take = cmd_pend && (cmd_op == OP_REFRESH);
            next_cas_n = 2'b00;  next_we_n = 1'b1;  next_dsf = 1'b1;
            next_cnt = 4'h0;  next_st = S_CBR_C;
          end
        end
        else if (cmd_pend && (page_hit || !page_open))
        begin
          take = 1'b1;
          next_cur_cmd = cmd_reg;  next_cur_addr = addr_reg;  next_cur_wdata = wdata_reg;
          next_st = S_ROW;  next_cnt = 4'h0;
          if (!page_open)
          begin
            next_ras_n = 1'b0;  next_trg_n = 1'b1;
            next_addr  = addr_reg[ADDR_ROW_LSB +: 9];
            next_cnt   = 4'(RCD_CYC - 1);
            // write strobe low at row strobe selects a masked write
            next_we_n  = ~cmd_key[1];
            // special-function high at this row strobe only to load the mask
            next_dsf   = cmd_key[0];
            next_dq    = mask_reg;
            // in persistent mode the pins are left undriven at row strobe
            next_dq_oe = cmd_key[1] & ~persistent;
          end
        end
        else if (cmd_pend || (page_open && ras_age >= 12'(RASP_CYC)))
          next_st = S_CLOSE;
      end
      S_ROW:
        if (cnt == 4'h0)
        begin
          // special-function low at column strobe for a normal write
          next_dsf = 1'b0;
          // column address is don't care for a mask load, sent anyway
          next_addr = cur_addr[ADDR_COL_LSB +: 9];
          next_cas_n = (cur_op == OP_READ) ? 2'b00 : ~cur_cmd[CMD_BYTE_LSB +: 2];
          // early writes leave output enable high past the row hold
          next_trg_n = !((cur_op == OP_READ) || (cur_op == OP_RMW));
          // mask or data valid as both column and write strobes fall
          next_we_n  = !((cur_op == OP_EARLY) || (cur_op == OP_LOADMSK));
          next_dq    = (cur_op == OP_LOADMSK) ? mask_reg : cur_wdata;
          next_dq_oe = (cur_op == OP_EARLY) || (cur_op == OP_LOADMSK);
          next_cnt   = ((cur_op == OP_READ) || (cur_op == OP_RMW)) ? 4'(CAC_CYC - 1) :
                       (cur_op == OP_LATE) ? 4'h0 : 4'(CWL_CYC - 1);
          next_st = S_COL;
        end
      S_COL:
        if (cnt == 4'h0)
        begin
          next_rdata = i_random_data_io;
          if (cur_op == OP_LATE)
          begin
            // output enable stays high, so the device never drives here
            next_we_n = 1'b0;  next_dq_oe = 1'b1;  next_cnt = 4'(CWL_CYC - 1);
            next_st = S_WR;
          end
          else if (cur_op == OP_RMW)
          begin
            // outputs off first, data follows after the turn-off gap
            next_trg_n = 1'b1;  next_cnt = 4'(GHD_CYC - 1);  next_st = S_GAP;
          end
          else
          begin
            next_rdata = (cur_op == OP_READ) ? i_random_data_io : rdata;
            next_cas_n = 2'b11;  next_we_n = 1'b1;  next_trg_n = 1'b1;  next_dq_oe = 1'b0;
            next_st = S_END;
          end
        end
      S_GAP:
        if (cnt == 4'h0)
        begin
          next_we_n = 1'b0;  next_dq_oe = 1'b1;  next_cnt = 4'(CWL_CYC - 1);  next_st = S_WR;
        end
      S_WR:
        if (cnt == 4'h0)
        begin
          next_cas_n = 2'b11;  next_we_n = 1'b1;  next_dq_oe = 1'b0;  next_st = S_END;
        end
      S_END:
      begin
        // the device now reuses its stored mask
        if (cur_op == OP_LOADMSK)
          next_persistent = 1'b1;
        if (cur_cmd[CMD_KEEP_BIT])
        begin
          next_page_open = 1'b1;
          next_open_row  = cur_addr[ADDR_ROW_LSB +: 9];
          if (!page_open)
            next_open_key = {cur_cmd[CMD_MASK_BIT] & is_write(cur_op), cur_op == OP_LOADMSK};
          // a late write pins output enable high for the rest of the page
          next_late_pg = late_pg | (cur_op == OP_LATE);
          next_st = S_IDLE;
        end
        else
          next_st = S_CLOSE;
      end
      S_CLOSE:
        if (ras_age >= 12'(RAS_CYC))
        begin
          next_ras_n = 1'b1;  next_trg_n = 1'b1;  next_page_open = 1'b0;  next_late_pg = 1'b0;
          next_cnt = 4'(RP_CYC - 1);  next_st = S_PRE;
        end
      S_PRE:
        if (cnt == 4'h0)
          next_st = S_IDLE;
      S_CBR_C:
        if (cnt == 4'h0)
        begin
          next_ras_n = 1'b0;  next_cnt = 4'(RAS_CYC - 1);  next_st = S_CBR_R;
        end
      S_CBR_R:
        if (cnt == 4'h0)
        begin
          // one row refreshed, the timer request is answered
          next_ras_n = 1'b1;  next_cas_n = 2'b11;  next_dsf = 1'b0;
          next_ref_ack = ref_link.req;  next_cnt = 4'(RP_CYC - 1);  next_st = S_PRE;
        end
      default:
        next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= S_IDLE;  cnt <= 4'h0;  ras_age <= 12'h000;
      page_open <= 1'b0;  late_pg <= 1'b0;  open_row <= 9'h000;  open_key <= 2'h0;
      persistent <= 1'b0;
      ras_n <= 1'b1;  cas_n <= 2'b11;  we_n <= 1'b1;  trg_n <= 1'b1;  special_function_select <= 1'b0;
      addr <= 9'h000;  dq <= 16'h0000;  dq_oe <= 1'b0;  rdata <= 16'h0000;
      ref_ack <= 1'b0;  cur_cmd <= CMD_RST;  cur_addr <= 32'h0000_0000;  cur_wdata <= 16'h0000;
    end
    else
    begin
      st <= next_st;  cnt <= next_cnt;  ras_age <= next_ras_age;
      page_open <= next_page_open;  late_pg <= next_late_pg;
      open_row <= next_open_row;  open_key <= next_open_key;  persistent <= next_persistent;
      ras_n <= next_ras_n;  cas_n <= next_cas_n;  we_n <= next_we_n;  trg_n <= next_trg_n;
      special_function_select <= next_dsf;  addr <= next_addr;  dq <= next_dq;  dq_oe <= next_dq_oe;
      rdata <= next_rdata;  ref_ack <= next_ref_ack;
      cur_cmd <= next_cur_cmd;  cur_addr <= next_cur_addr;  cur_wdata <= next_cur_wdata;
    end
  end

  assign ref_link.ack = ref_ack;
  assign o_wb_ack = wb_ack;  assign o_wb_dat = wb_dat;
  assign o_row_strobe_n = ras_n;  assign o_write_strobe_n = we_n;
  assign o_lower_byte_column_strobe_n = cas_n[0];
  assign o_upper_byte_column_strobe_n = cas_n[1];
  assign o_output_enable_transfer_select_n = trg_n;  assign o_special_function_select = special_function_select;
  assign o_addr = addr;  assign o_random_data_io = dq;  assign o_random_data_io_oe = dq_oe;

  // checks on the pin sequencing
  a_oe_before_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_random_data_io_oe |-> o_output_enable_transfer_select_n) else $error("data driven with oe low");
  a_rmw_turn_gap: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_random_data_io_oe) && cur_op == OP_RMW |-> $past(o_output_enable_transfer_select_n, 1))
    else $error("rmw data driven without gap");
  a_dsf_col_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_lower_byte_column_strobe_n) && !o_row_strobe_n |-> !o_special_function_select)
    else $error("special function high at column strobe");
  a_late_page_trg: assert property (@(posedge i_core_clk) disable iff (i_rst)
    late_pg |-> o_output_enable_transfer_select_n) else $error("oe low in late-write page");
  a_masked_ras: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_row_strobe_n) && o_lower_byte_column_strobe_n && cur_cmd[CMD_MASK_BIT] &&
    is_write(cur_op) && !persistent
    |-> !o_write_strobe_n && o_random_data_io_oe && o_random_data_io == mask_reg)
    else $error("masked write without mask at row strobe");
  a_unmasked_ras: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_row_strobe_n) && o_lower_byte_column_strobe_n && !cur_cmd[CMD_MASK_BIT]
    |-> o_write_strobe_n) else $error("unmasked write with write strobe low");
  a_trg_ras_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_row_strobe_n) |-> o_output_enable_transfer_select_n &&
    $past(o_output_enable_transfer_select_n)) else $error("oe low within row hold");
  a_page_row_held: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st == S_IDLE && page_open |-> !o_row_strobe_n && o_lower_byte_column_strobe_n)
    else $error("open page lost its row strobe");
  a_ras_precharge: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_row_strobe_n) |-> o_row_strobe_n [*3]) else $error("row precharge too short");
endmodule : vrc_ctrl

// >>> test/vrc_mem_model.sv
// Purpose: behavioural random port of the video memory
// Assumes: pins settle 1 ns after each strobe edge
// Notes: mask register unknown until loaded
`timescale 1ns/1ps
module vrc_mem_model (
  input  wire logic        i_ras_n, // row strobe
  input  wire logic        i_cas_n, // any column strobe
  input  wire logic        i_we_n,  // write strobe
  input  wire logic        i_trg_n, // output enable
  input  wire logic        i_dsf,   // special function
  input  wire logic [8:0]  i_addr,  // address
  input  wire logic [15:0] i_dq,    // data pins
  output logic      [15:0] o_q,     // read data
  output logic             o_q_oe,  // driving pins
  output int               o_refs   // refreshes seen
);
  logic [15:0] mem [int];
  logic [15:0] wmask, rmask;
  logic [8:0]  row;
  logic        pers = 0, loadm, done = 0;
  initial o_refs = 0;
  // mask source chosen at row fall
  always @(negedge i_ras_n)
  begin
    #1;
    if (!i_cas_n) o_refs++;
    row = i_addr;
    loadm = i_dsf;
    rmask = i_we_n ? 16'hffff : (pers ? wmask : i_dq);
  end
  // data taken at the later strobe fall
  always @(negedge i_cas_n or negedge i_we_n)
  begin
    #1;
    if (!i_ras_n && !i_cas_n && !i_we_n && !done)
    begin
      done = 1;
      if (loadm) {pers, wmask} = {1'b1, i_dq};
      else mem[{row, i_addr}] = (mem[{row, i_addr}] & ~rmask) | (i_dq & rmask);
    end
  end
  always @(posedge i_cas_n) done = 0;
  // drives only in reads, never once writing
  assign o_q_oe = !i_ras_n && !i_cas_n && !i_trg_n && i_we_n;
  always @(negedge i_cas_n) #1 o_q = mem.exists({row, i_addr}) ? mem[{row, i_addr}] : 16'h0;
endmodule : vrc_mem_model

// >>> test/vrc_ctrl_tb_top.sv
// Purpose: register level checks of the random port controller
// Assumes: answers within 50 cycles, commands within 100 polls
// Notes: an undriven pin shows the inverted last value
`timescale 1ns/1ps
module vrc_ctrl_tb_top;
  import vrc_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, ras_n, cl_n, cu_n, we_n, trg_n, special_function_select;
  logic oe, q_oe;
  logic [7:0] adr = 8'h00;
  logic [8:0] addr;
  logic [15:0] d, q, dq, last = 16'h0;
  logic [31:0] wdat = 32'h0, rdat, rdv;
  logic [15:0] tc [7] = '{16'h61, 16'h69, 16'h6a, 16'h63, 16'h64, 16'h69, 16'h71};
  logic [15:0] tw [7] = '{16'h1234, 16'habcd, 16'h5555, 16'h0f0f, 16'h0, 16'hffff, 16'h1111};
  logic [15:0] tm [7] = '{16'hffff, 16'h00ff, 16'hff00, 16'hffff, 16'h3c3c, 16'hffff, 16'hffff};
  logic [15:0] te [7] = '{16'h1234, 16'h12cd, 16'h55cd, 16'h0f0f, 16'h0f0f, 16'h3f3f, 16'h1111};
  int err_count = 0, comparisons = 0, clash = 0, refs, n0;
  always #12.5 clk = ~clk;
  assign dq = oe ? d : (q_oe ? q : ~last);
  // both sides driving at once is a bus fight
  always @(posedge clk)
  begin
    last <= dq;
    if (oe && q_oe) clash++;
  end
  vrc_ctrl i_vrc_ctrl (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_row_strobe_n(ras_n), .o_lower_byte_column_strobe_n(cl_n),
    .o_upper_byte_column_strobe_n(cu_n), .o_write_strobe_n(we_n),
    .o_output_enable_transfer_select_n(trg_n), .o_special_function_select(special_function_select),
    .o_addr(addr), .i_random_data_io(dq), .o_random_data_io(d), .o_random_data_io_oe(oe));
  vrc_mem_model i_vrc_mem_model (.i_ras_n(ras_n), .i_cas_n(cl_n & cu_n), .i_we_n(we_n),
    .i_trg_n(trg_n), .i_dsf(special_function_select), .i_addr(addr), .i_dq(dq), .o_q(q), .o_q_oe(q_oe),
    .o_refs(refs));
  task automatic results;
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle, held until ack is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, v};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdv = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 50) chk("ack", 1, 0);
    if (n >= 50) results();
  endtask : bus
  task automatic go(input logic [31:0] c);
    int n;
    n = 0;
    bus(1, ADR_CMD, c);
    do
    begin
      bus(0, ADR_STATUS, 0);
      n++;
    end while (rdv[ST_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) chk("busy", 0, 1);
    if (n >= 100) results();
  endtask : go
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    bus(0, ADR_MASK, 0);
    chk("mask", 32'hffff, rdv);
    bus(0, ADR_STATUS, 0);
    chk("pers", 0, rdv[ST_PERS_BIT]);
    bus(0, 8'h1c, 0);
    chk("unmapped", 0, rdv);
    bus(1, ADR_ADDR, 32'h0003_0005);
    // each command except refresh, then a plain read back of the same cell
    for (int i = 0; i < 7; i++)
    begin
      bus(1, ADR_WDATA, tw[i]);
      bus(1, ADR_MASK, tm[i]);
      go(tc[i]);
      go(32'h60);
      bus(0, ADR_RDATA, 0);
      chk("cell", te[i], rdv);
    end
    bus(0, ADR_STATUS, 0);
    chk("pers", 1, rdv[ST_PERS_BIT]);
    n0 = refs;
    repeat (700) @(posedge clk);
    chk("refresh", 1, refs > n0);
    n0 = refs;
    go(32'h65);
    chk("refcmd", 1, refs > n0);
    chk("clash", 0, clash);
    // open a page, then a miss keeps a command pending so a second one is refused
    go(32'h71);
    bus(0, ADR_STATUS, 0);
    chk("page", 1, rdv[ST_PAGE_BIT]);
    bus(1, ADR_ADDR, 32'h0004_0005);
    bus(1, ADR_CMD, 32'h60);
    go(32'h60);
    chk("dropped", 1, rdv[ST_DROP_BIT]);
    bus(1, ADR_STATUS, 32'h8);
    bus(0, ADR_STATUS, 0);
    chk("dropclr", 0, rdv[ST_DROP_BIT]);
    // a second reset in mid-run returns to nonpersistent tracking
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    bus(0, ADR_STATUS, 0);
    chk("pers", 0, rdv[ST_PERS_BIT]);
    bus(0, ADR_MASK, 0);
    chk("mask", 32'hffff, rdv);
    results();
  end
endmodule : vrc_ctrl_tb_top
